//--- rtl/srbs_map.vh
// register map, field positions and command codes of the readback block
`ifndef SRBS_MAP_VH
`define SRBS_MAP_VH
`define SRBS_FRAME_BITS 24
`define SRBS_FRAME_CNT 5'h18
`define SRBS_RW_BIT 23
`define SRBS_ADDR_HI 22
`define SRBS_ADDR_LO 21
`define SRBS_SEL_HI 20
`define SRBS_SEL_LO 16
`define SRBS_NOP_WORD 24'h1CE000
`define SRBS_SEL_DATA 5'h00
`define SRBS_SEL_CTRL 5'h04
`define SRBS_SEL_GAIN 5'h08
`define SRBS_SEL_OFFS 5'h0C
`define SRBS_SEL_CLRC 5'h10
`define SRBS_SEL_SLEW 5'h14
`define SRBS_SEL_STAT 5'h18
`define SRBS_SEL_MAIN 5'h19
`define SRBS_SEL_BOOST 5'h1A
`define SRBS_SLEW_EN_BIT 12
`define SRBS_SLEW_RATE_HI 6
`define SRBS_SLEW_RATE_LO 3
`define SRBS_SLEW_STEP_HI 2
`define SRBS_SLEW_STEP_LO 0
`define SRBS_ST_BOOST_LO 12
`define SRBS_ST_TOGGLE 11
`define SRBS_ST_FCERR 10
`define SRBS_ST_RAMP 9
`define SRBS_ST_HOT 8
`define SRBS_ST_OUTF_LO 0
`endif

//--- rtl/srbs_readback_status.v
// serial readback path and fault status register
// How it works
// RQ1: a frame with bit 23 set is a readback request, not a write.
// RQ2: device address bits plus selector bits 20..16 choose the register.
// RQ3: low sixteen bits of a readback request are ignored.
// RQ4: next transfer shifts out the register chosen by the request.
// RQ5: host follows a request with another request or a no-op.
// RQ6: no-op word is 0x1CE000 with address in bits 22..21.
// RQ7: selectors 0-3 data, 4-7 control registers of channels A-D.
// RQ8: selectors 8-11 gain, 12-15 offset registers of channels A-D.
// RQ9: selectors 16-19 clear-code, 20-23 slew registers of channels A-D.
// RQ10: selector 24 status, 25 main control, 26 boost control.
// RQ11: slew word: zeros 15..13, enable 12, rate 6..3, step 2..0.
// RQ12: sixteen-bit read-only status with faults, ramp and toggle flags.
// RQ13: status-on-write set means status shifts out during every write.
// RQ14: boost-limit flag of a channel forces its output fault flag.
// RQ15: user toggle flag follows the value written by the host.
// RQ16: frame check error flag set when last word fails its check.
// RQ17: ramp-active high while any channel is still slewing.
// RQ18: overheat flag set when over-temperature detector reports.
// RQ19: one output fault flag per channel set by its pin fault.
// RQ20: toggle flag at status bit 11 loads from software write bit 12.
// RQ21: status read clears frame check error; fault output releases once no fault flag remains.
// RQ22: status-on-write is off after reset.
// RQ23: selectors above 26 return all zeros.
// RQ24: requests for another device address are ignored, output undriven.
`include "srbs_map.vh"
`default_nettype none
module srbs_readback_status (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial link pins
  input wire sclk,
  input wire syncN,
  input wire sdin,
  output reg sdo,
  output reg sdoOe,
  // strap of this device's address
  input wire [1:0] deviceAddr,
  // register contents held elsewhere, channel A in the low word
  input wire [63:0] dataRegs,
  input wire [63:0] ctrlRegs,
  input wire [63:0] gainRegs,
  input wire [63:0] offsRegs,
  input wire [63:0] clrcRegs,
  input wire [15:0] mainCtrl,
  input wire [15:0] boostCtrl,
  // main control bit and software register write strobe
  input wire statusOnWrite,
  input wire swWrite,
  input wire swToggle,
  input wire slewWrite,
  input wire [1:0] slewChan,
  input wire [15:0] slewWord,
  // event sources from the analogue side and frame checker
  input wire [3:0] boostLimit,
  input wire [3:0] outFault,
  input wire frameCheckFail,
  input wire overTemp,
  input wire [3:0] slewing,
  // status outputs
  output reg [15:0] faultStatus,
  output reg faultN,
  output reg [63:0] slewRateConfig
);
  // synchroniser stages of the pins
  reg [2:0] sclkS_q;
  reg [2:0] syncS_q;
  reg [1:0] sdinS_q;
  reg [1:0] addrMeta_q;
  reg [1:0] addrSync_q;
  reg [12:0] anaMeta_q;
  reg [12:0] anaSync_q;
  // link and request state
  reg [23:0] shiftIn_q;
  reg [23:0] shiftOut_q;
  reg [4:0] bitCnt_q;
  reg pendRead_q;
  reg [4:0] pendSel_q;
  reg pendMatch_q;
  // status flags
  reg toggle_q;
  reg fcErr_q;
  reg status_on_write_q;
  // combinational helpers
  reg [15:0] statusV;
  reg [15:0] loadWord;
  reg loadEn;
  reg loadDrive;
  wire sclkRise = sclkS_q[1] & ~sclkS_q[2];
  wire sclkFall = ~sclkS_q[1] & sclkS_q[2];
  wire frameStart = ~syncS_q[1] & syncS_q[2];
  wire frameEnd = syncS_q[1] & ~syncS_q[2];
  wire [23:0] word = shiftIn_q;
  // status leaves the device in the frame that starts now
  wire statusShown = frameStart && ((pendRead_q && pendMatch_q &&
    pendSel_q == `SRBS_SEL_STAT) || (!pendRead_q && status_on_write_q));
  // analogue levels after their synchronisers
  wire [3:0] boostS = anaSync_q[12:9];
  wire [3:0] outFaultS = anaSync_q[8:5];
  wire overTempS = anaSync_q[4];
  wire [3:0] slewingS = anaSync_q[3:0];
  integer i;

  function [15:0] pick4;
    input [63:0] regs;
    input [1:0] ch;
    begin
      pick4 = regs[ch*16 +: 16];
    end
  endfunction

  // RQ7 RQ8 RQ9 RQ10 RQ23 selector decode
  function [15:0] decodeSel;
    input [4:0] sel;
    input [15:0] st;
    begin
      case (sel[4:2])
        3'h0: decodeSel = pick4(dataRegs, sel[1:0]);
        3'h1: decodeSel = pick4(ctrlRegs, sel[1:0]);
        3'h2: decodeSel = pick4(gainRegs, sel[1:0]);
        3'h3: decodeSel = pick4(offsRegs, sel[1:0]);
        3'h4: decodeSel = pick4(clrcRegs, sel[1:0]);
        3'h5: decodeSel = pick4(slewRateConfig, sel[1:0]);
        3'h6: begin
          if (sel == `SRBS_SEL_STAT) begin
            decodeSel = st;
          end else if (sel == `SRBS_SEL_MAIN) begin
            decodeSel = mainCtrl;
          end else if (sel == `SRBS_SEL_BOOST) begin
            decodeSel = boostCtrl;
          end else begin
            decodeSel = 16'h0000;
          end
        end
        // RQ23 selectors 28 to 31 name no register
        3'h7: decodeSel = 16'h0000;
        default: decodeSel = 16'h0000;
      endcase
    end
  endfunction

  // RQ12 RQ14 RQ17 RQ18 RQ19 status composition
  always @* begin
    statusV = 16'h0000;
    statusV[`SRBS_ST_BOOST_LO +: 4] = boostS;
    statusV[`SRBS_ST_TOGGLE] = toggle_q;
    statusV[`SRBS_ST_FCERR] = fcErr_q;
    statusV[`SRBS_ST_RAMP] = |slewingS;
    statusV[`SRBS_ST_HOT] = overTempS;
    // boost limit also raises the channel's output fault
    statusV[`SRBS_ST_OUTF_LO +: 4] = outFaultS | boostS;
  end

  // choose what the coming frame shifts out
  always @* begin
    loadWord = 16'h0000;
    loadEn = 1'b0;
    loadDrive = 1'b0;
    if (pendRead_q) begin
      loadEn = 1'b1;
      // a foreign request still shifts, only with the driver off
      // RQ24 foreign address
      loadDrive = pendMatch_q;
      // RQ4 previous selection
      loadWord = decodeSel(pendSel_q, statusV);
    end else if (status_on_write_q) begin
      // RQ13 status on write
      loadEn = 1'b1;
      loadDrive = 1'b1;
      loadWord = statusV;
    end
  end

  // pins from outside the clock domain pass two flip-flops first
  // the third stage of clock and sync feeds edge detection, and that of sync also gates shifting
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkS_q <= 3'h0;
      syncS_q <= 3'h7;
      sdinS_q <= 2'h0;
      addrMeta_q <= 2'h0;
      addrSync_q <= 2'h0;
      anaMeta_q <= 13'h0000;
      anaSync_q <= 13'h0000;
    end else begin
      sclkS_q <= {sclkS_q[1:0], sclk};
      syncS_q <= {syncS_q[1:0], syncN};
      sdinS_q <= {sdinS_q[0], sdin};
      addrMeta_q <= deviceAddr;
      addrSync_q <= addrMeta_q;
      anaMeta_q <= {boostLimit, outFault, overTemp, slewing};
      anaSync_q <= anaMeta_q;
    end
  end

  // RQ4 frame shifter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn_q <= 24'h000000;
      shiftOut_q <= 24'h000000;
      bitCnt_q <= 5'h00;
      sdo <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      if (frameStart) begin
        bitCnt_q <= 5'h00;
        sdoOe <= loadEn & loadDrive;
        // eight trailing bits read as zero
        shiftOut_q <= {loadWord, 8'h00};
        sdo <= loadWord[15];
      end else if (!syncS_q[2] && sclkFall) begin
        shiftIn_q <= {shiftIn_q[22:0], sdinS_q[1]};
        // saturate so an overlong frame never wraps back to 24
        if (bitCnt_q != 5'h1F) begin
          bitCnt_q <= bitCnt_q + 5'h01;
        end
      end else if (!syncS_q[2] && sclkRise) begin
        shiftOut_q <= {shiftOut_q[22:0], 1'b0};
        sdo <= shiftOut_q[22];
      end
      // release the output as soon as the frame closes
      if (frameEnd) begin
        sdoOe <= 1'b0;
      end
    end
  end

  // RQ1 RQ2 RQ3 request capture
  // RQ6 no-op is no request
  // a no-op has bit 23 clear, so it leaves nothing pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendRead_q <= 1'b0;
      pendSel_q <= 5'h00;
      pendMatch_q <= 1'b0;
    end else if (frameEnd) begin
      pendRead_q <= word[`SRBS_RW_BIT] &&
        bitCnt_q == `SRBS_FRAME_CNT;
      pendSel_q <= word[`SRBS_SEL_HI:`SRBS_SEL_LO];
      pendMatch_q <=
        word[`SRBS_ADDR_HI:`SRBS_ADDR_LO] == addrSync_q;
    end
  end

  // RQ22 follows main control, cleared at reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_on_write_q <= 1'b0;
    end else begin
      status_on_write_q <= statusOnWrite;
    end
  end

  // RQ15 RQ20 toggle follows write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_q <= 1'b0;
    end else if (swWrite) begin
      toggle_q <= swToggle;
    end
  end

  // RQ16 RQ21 set wins over read clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fcErr_q <= 1'b0;
    end else if (frameCheckFail) begin
      fcErr_q <= 1'b1;
    end else if (statusShown) begin
      fcErr_q <= 1'b0;
    end
  end

  // RQ11 slew word layout
  // ignored bits 11..7 read back as zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slewRateConfig <= 64'h0;
    end else if (slewWrite) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (slewChan == i[1:0]) begin
          slewRateConfig[i*16 +: 16] <= {3'h0,
            slewWord[`SRBS_SLEW_EN_BIT], 5'h00,
            slewWord[`SRBS_SLEW_RATE_HI:`SRBS_SLEW_RATE_LO],
            slewWord[`SRBS_SLEW_STEP_HI:`SRBS_SLEW_STEP_LO]};
        end
      end
    end
  end

  // RQ12 RQ21 registered status and fault pin
  // plain level, the open-drain stage sits outside
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultStatus <= 16'h0000;
      faultN <= 1'b1;
    end else begin
      faultStatus <= statusV;
      faultN <= ~(fcErr_q | overTempS | (|outFaultS) | (|boostS));
    end
  end
endmodule // srbs_readback_status
`default_nettype wire

//--- tb/srbs_readback_monitor.sv
// checker of the status and link outputs
`default_nettype none
module srbs_readback_monitor (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // link and writes
  input wire syncN,
  input wire sdoOe,
  input wire swWrite,
  input wire swToggle,
  // fault sources
  input wire [3:0] outFault,
  input wire overTemp,
  input wire [3:0] slewing,
  // status
  input wire [15:0] faultStatus,
  input wire faultN,
  input wire [63:0] slewRateConfig
);
  timeunit 1ns;
  timeprecision 10ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  slew_zeros_a: assert property (
    (slewRateConfig & 64'hEF80EF80EF80EF80) == 64'h0) else $error("slew bits");
  boost_out_a: assert property (
    (faultStatus[15:12] & ~faultStatus[3:0]) == 4'h0) else $error("boost");
  hot_flag_a: assert property (
    $rose(overTemp) |-> ##[1:4] faultStatus[8]) else $error("no heat flag");
  pin_fault_a: assert property (
    $rose(outFault[0]) |-> ##[1:4] faultStatus[0]) else $error("no pin flag");
  ramp_flag_a: assert property (
    (slewing != 4'h0) [*4] |-> faultStatus[9]) else $error("no ramp flag");
  toggle_copy_a: assert property (
    swWrite && swToggle |-> ##[1:4] faultStatus[11]) else $error("toggle");
  idle_quiet_a: assert property (
    syncN [*6] |-> !sdoOe) else $error("drive outside frame");
  fault_out_a: assert property (
    faultStatus[8] [*3] |-> !faultN) else $error("fault pin high");
endmodule // srbs_readback_monitor
bind srbs_readback_status srbs_readback_monitor mon_u (.clk, .rst_n,
  .syncN, .sdoOe, .swWrite, .swToggle, .outFault, .overTemp, .slewing,
  .faultStatus, .faultN, .slewRateConfig);
`default_nettype wire

//--- tb/srbs_host_model.sv
// host end of the serial link
`default_nettype none
module srbs_host_model (
  // link pins
  output logic sclk,
  output logic syncN,
  output logic sdin,
  input wire sdo,
  input wire sdoOe
);
  timeunit 1ns;
  timeprecision 10ps;
  logic seenOe;
  initial begin
    sclk = 1'h0;
    syncN = 1'h1;
    sdin = 1'h0;
  end
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    seenOe = 1'h0;
    syncN = 1'h0;
    #70;
    // data moves mid low phase, away from the sampling fall
    for (int i = 23; i >= 0; i--) begin
      #31.25 sdin = w[i];
      // a released line floats, so show it inverted
      r[i] = sdoOe ? sdo : ~sdo;
      seenOe |= sdoOe;
      #31.25 sclk = 1'h1;
      #62.5 sclk = 1'h0;
    end
    #62.5 syncN = 1'h1;
    sdin = ~sdin;
    #250;
  endtask
endmodule // srbs_host_model
`default_nettype wire

//--- tb/srbs_readback_status_tb.sv
// self-checking bench of the readback block
`default_nettype none
module srbs_readback_status_tb;
  timeunit 1ns;
  timeprecision 10ps;
  logic clk = 1'h0, rst_n = 1'h0, statusOnWrite = 1'h0, swWrite = 1'h0;
  logic swToggle = 1'h0, slewWrite = 1'h0, frameCheckFail = 1'h0;
  logic overTemp = 1'h0;
  logic [1:0] slewChan = 2'h0;
  logic [3:0] boostLimit = 4'h0, outFault = 4'h0, slewing = 4'h0;
  logic [15:0] slewWord = 16'h0, ex[28];
  logic [23:0] rx;
  wire sclk, syncN, sdin, sdo, sdoOe, faultN;
  wire [15:0] faultStatus;
  wire [63:0] slewRateConfig;
  int num_errors = 0, checks_done = 0, cyc = 0;
  srbs_host_model host_u (.sclk, .syncN, .sdin, .sdo, .sdoOe);
  srbs_readback_status dut_u (.clk, .rst_n, .sclk, .syncN, .sdin, .sdo,
    .sdoOe, .deviceAddr(2'h1), .dataRegs({ex[3], ex[2], ex[1], ex[0]}),
    .ctrlRegs({ex[7], ex[6], ex[5], ex[4]}),
    .gainRegs({ex[11], ex[10], ex[9], ex[8]}),
    .offsRegs({ex[15], ex[14], ex[13], ex[12]}),
    .clrcRegs({ex[19], ex[18], ex[17], ex[16]}), .mainCtrl(ex[25]),
    .boostCtrl(ex[26]), .statusOnWrite, .swWrite, .swToggle, .slewWrite,
    .slewChan, .slewWord, .boostLimit, .outFault, .frameCheckFail,
    .overTemp, .slewing, .faultStatus, .faultN, .slewRateConfig);
  always #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // low sixteen bits all ones: they must not matter
  task automatic rd(input logic [4:0] s);
    host_u.xfer({3'h5, s, 16'hFFFF}, rx);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    for (int i = 0; i < 28; i++) ex[i] = {i[7:0], ~i[7:0]};
    ex[27] = 16'h0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'h1;
    for (int c = 0; c < 4; c++) begin
      repeat (4) @(posedge clk);
      #1 slewChan = c[1:0];
      slewWord = 16'hFFF8 + c[15:0];
      slewWrite = 1'h1;
      ex[20 + c] = 16'h1078 + c[15:0];
      @(posedge clk) #1 slewWrite = 1'h0;
    end
    @(posedge clk) #1 swToggle = 1'h1;
    swWrite = 1'h1;
    {boostLimit, outFault, overTemp, slewing} = {4'h2, 4'h1, 1'h1, 4'h4};
    ex[24] = 16'h2B03;
    @(posedge clk) #1 swWrite = 1'h0;
    repeat (9) @(posedge clk);
    chk(faultStatus, ex[24]);
    chk({15'h0, faultN}, 16'h0);
    $display("status test done");
    for (int s = 0; s < 29; s++) begin
      if (s < 28) rd(s[4:0]);
      else host_u.xfer(24'h3CE000, rx);
      if (s > 0) chk(rx[23:8], ex[s - 1]);
    end
    $display("sweep test done");
    host_u.xfer(24'hD80000, rx);
    host_u.xfer(24'h5CE000, rx);
    chk({15'h0, host_u.seenOe}, 16'h0);
    @(posedge clk) #1 frameCheckFail = 1'h1;
    @(posedge clk) #1 frameCheckFail = 1'h0;
    repeat (9) @(posedge clk);
    chk(faultStatus, ex[24] | 16'h0400);
    rd(5'h18);
    host_u.xfer(24'h3CE000, rx);
    chk(rx[23:8], ex[24] | 16'h0400);
    chk(faultStatus, ex[24]);
    $display("frame error test done");
    @(posedge clk) #1 statusOnWrite = 1'h1;
    host_u.xfer(24'h3CE000, rx);
    chk(rx[23:8], ex[24]);
    $display("write status test done");
    @(posedge clk) #1 swToggle = 1'h0;
    swWrite = 1'h1;
    {boostLimit, outFault, overTemp, slewing} = 13'h0000;
    @(posedge clk) #1 swWrite = 1'h0;
    repeat (9) @(posedge clk);
    chk(faultStatus, 16'h0000);
    chk({15'h0, faultN}, 16'h0001);
    $display("fault release test done");
    conclude();
  end
endmodule // srbs_readback_status_tb
`default_nettype wire
